// ---- design/dmib_pkg.sv ----
// Purpose: Shared constants for the mode information and burst order block
// Assumes: 8-bit mode register operands, addresses on an 8-bit mode address
// Notes: Reset values follow the documented defaults of the feature register
package dmib_pkg;
   localparam logic [7:0] ADDR_DEVICE_INFO_STATUS = 8'h00;
   localparam logic [7:0] ADDR_BURST_FEATURE_CFG = 8'h01;
   localparam int POS_AUTO_INIT = 0;
   localparam int POS_CLASS_INFO = 1;
   localparam int POS_INVALID_DATA = 2;
   localparam int POS_SELFTEST_LO = 3;
   localparam int POS_BL_LO = 0;
   localparam int POS_BT = 3;
   localparam int POS_WC = 4;
   localparam int POS_WR_LO = 5;
   localparam logic [2:0] BL_CODE_4 = 3'h2;
   localparam logic [2:0] BL_CODE_8 = 3'h3;
   localparam logic [2:0] BL_CODE_16 = 3'h4;
   localparam logic [2:0] WR_CODE_MIN = 3'h1;
   localparam logic [2:0] WR_CODE_MAX = 3'h6;
   localparam logic [3:0] WR_CYCLES_OFFSET = 4'h2;
   localparam logic [2:0] RST_BL = BL_CODE_4;
   localparam logic RST_BT = 1'b0;
   localparam logic RST_WC = 1'b0;
   localparam logic [2:0] RST_WR = WR_CODE_MIN;
   localparam logic [1:0] ST_NOT_SUPPORTED = 2'h0;
   localparam logic [1:0] ST_OPEN_OR_SUPPLY = 2'h1;
   localparam logic [1:0] ST_SHORT_GROUND = 2'h2;
   localparam logic [1:0] ST_PASS = 2'h3;
   localparam logic [3:0] AUTO_INIT_CYCLES = 4'hA;
   localparam logic [7:0] CAL_CYCLES = 8'h14;
   typedef enum logic [1:0] {WR_IDLE, WR_WAIT, WR_PRECHARGE} dmib_wr_state_t;
endpackage

// ---- design/dmib_top.sv ----
// Purpose: Device-side mode information register, burst feature register,
//          write-recovery timer and column burst ordering
// Assumes: Mode commands arrive decoded and synchronous to CLK; pin levels
//          for the calibration self-test come from outside and are resynced
// Notes: One column address per cycle while a burst runs
//        Only one auto-precharge timer; a second write burst ending while
//        it still counts is not tracked, so the controller spaces them apart
//        The self-test field holds a fault until reset, so a fault found once
//        keeps calibration locked out even after the pin is repaired
//        Reserved burst length codes run as four beats
// Overview of operation
// RQ1: Self-test field bits 4:3, 00 unsupported
// RQ2: Field 01 open/supply, 10 shorted to ground
// RQ3: Field 11 after clean self-test with resistor
// RQ4: Update field when init calibration finishes
// RQ5: On fault use factory trim, ignore calibration
// RQ6: Bit 2 reads zero, no invalid-data info
// RQ7: Burst length code 2/3/4 for 4/8/16
// RQ8: Bit 3 burst type, bit 4 wrap
// RQ9: Write recovery codes 1..6 give 3..8
// RQ10: Wait write recovery before auto precharge
// RQ11: Controller rounds recovery time up to cycles
// RQ12: Four-beat wrap halves swap; no-wrap increments
// RQ13: Eight-beat sequential wraps modulo eight
// RQ14: Eight-beat interleaved XORs; controller avoids no-wrap
// RQ15: Column bit 0 always taken as zero
// RQ16: Controller writes reserved bits as zero
// RQ17: Writes to read-only register change nothing
// RQ18: Bit 0 high while auto-init runs
`timescale 1ns/10ps
module dmib_top (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic CE,
   input wire logic MODE_WR,
   input wire logic MODE_RD,
   input wire logic [7:0] MODE_ADDR,
   input wire logic [7:0] MODE_WDATA,
   input wire logic CAL_INIT_CMD,
   input wire logic CAL_CMD,
   input wire logic SELFTEST_EN,
   input wire logic PIN_OPEN_OR_SUPPLY,
   input wire logic PIN_SHORT_GROUND,
   input wire logic BURST_START,
   input wire logic [11:0] BURST_COL,
   input wire logic BURST_WRITE_AP,
   output logic [7:0] MODE_RDATA,
   output logic MODE_RVALID,
   output logic CAL_BUSY,
   output logic FACTORY_TRIM,
   output logic BURST_ACTIVE,
   output logic [11:0] COL_OUT,
   output logic PRECHARGE_START,
   output logic [2:0] BURST_LENGTH_SEL,
   output logic [3:0] WRITE_RECOVERY_CYCLES
);
   // Feature register fields, held as written, and the self-test info field
   logic [2:0] burst_length_sel_r;
   logic burst_order_type_r;
   logic wrap_control_sel_r;
   logic [2:0] write_recovery_code_r;
   logic [1:0] cal_pin_selftest_info_r;

   // Status and calibration state
   logic [3:0] auto_init_cnt_r;
   logic auto_init_flag_r;
   logic [7:0] cal_cnt_r;
   logic cal_busy_r;
   logic cal_is_init_r;

   // Pin level resynchronisers
   logic [2:0] open_sync_r;
   logic [2:0] short_sync_r;
   logic open_stable_r;
   logic short_stable_r;

   // Burst sequencer and recovery timer
   logic [11:0] base_col_r;
   logic [3:0] beat_r;
   logic [3:0] beats_m1_r;
   logic order_int_r;
   logic nowrap_r;
   logic is_wr_ap_r;
   logic [3:0] wr_cnt_r;
   dmib_pkg::dmib_wr_state_t wr_state_r;

   // Combinational helpers
   logic [3:0] wr_cycles;
   logic [3:0] beats_m1_nxt;
   logic [11:0] col_nxt;
   logic [7:0] info_byte;
   logic fault;

   // Reserved codes fall back to the minimum recovery so the timer never stalls
   always_comb begin
      if (write_recovery_code_r >= dmib_pkg::WR_CODE_MIN && write_recovery_code_r <= dmib_pkg::WR_CODE_MAX) begin
         wr_cycles = {1'b0, write_recovery_code_r} + dmib_pkg::WR_CYCLES_OFFSET; // [RQ9]
      end else begin
         wr_cycles = {1'b0, dmib_pkg::WR_CODE_MIN} + dmib_pkg::WR_CYCLES_OFFSET;
      end
   end

   // Reserved length codes fall back to four beats
   always_comb begin
      case (burst_length_sel_r) // [RQ7]
         dmib_pkg::BL_CODE_8: beats_m1_nxt = 4'h7;
         dmib_pkg::BL_CODE_16: beats_m1_nxt = 4'hF;
         default: beats_m1_nxt = 4'h3;
      endcase
   end

   assign fault = (cal_pin_selftest_info_r == dmib_pkg::ST_OPEN_OR_SUPPLY) ||
                  (cal_pin_selftest_info_r == dmib_pkg::ST_SHORT_GROUND);

   // Class bit reads zero: this part has no nonvolatile array
   always_comb begin
      info_byte = 8'h00;
      info_byte[dmib_pkg::POS_AUTO_INIT] = auto_init_flag_r; // [RQ18]
      info_byte[dmib_pkg::POS_CLASS_INFO] = 1'b0;
      info_byte[dmib_pkg::POS_INVALID_DATA] = 1'b0; // [RQ6]
      info_byte[dmib_pkg::POS_SELFTEST_LO +: 2] = cal_pin_selftest_info_r; // [RQ1]
   end

   // Mode register write: only the feature register stores anything
   always_ff @(posedge CLK) begin
      if (SRST) begin
         burst_length_sel_r <= dmib_pkg::RST_BL;
         burst_order_type_r <= dmib_pkg::RST_BT;
         wrap_control_sel_r <= dmib_pkg::RST_WC;
         write_recovery_code_r <= dmib_pkg::RST_WR;
      end else if (CE && MODE_WR && MODE_ADDR == dmib_pkg::ADDR_BURST_FEATURE_CFG) begin // [RQ17]
         burst_length_sel_r <= MODE_WDATA[dmib_pkg::POS_BL_LO +: 3]; // [RQ7]
         burst_order_type_r <= MODE_WDATA[dmib_pkg::POS_BT]; // [RQ8]
         wrap_control_sel_r <= MODE_WDATA[dmib_pkg::POS_WC]; // [RQ8]
         write_recovery_code_r <= MODE_WDATA[dmib_pkg::POS_WR_LO +: 3]; // [RQ9]
      end
   end

   // Feature register is write-only, so reads return zero except the info register
   always_ff @(posedge CLK) begin
      if (SRST) begin
         MODE_RDATA <= 8'h00;
         MODE_RVALID <= 1'b0;
      end else if (CE) begin
         MODE_RVALID <= MODE_RD;
         if (MODE_RD && MODE_ADDR == dmib_pkg::ADDR_DEVICE_INFO_STATUS) begin
            MODE_RDATA <= info_byte;
         end else begin
            MODE_RDATA <= 8'h00;
         end
      end
   end

   // Auto-init runs once after reset; no command restarts it
   always_ff @(posedge CLK) begin
      if (SRST) begin
         auto_init_cnt_r <= dmib_pkg::AUTO_INIT_CYCLES;
         auto_init_flag_r <= 1'b1;
      end else if (CE && auto_init_flag_r) begin
         if (auto_init_cnt_r == 4'h1) begin
            auto_init_flag_r <= 1'b0; // [RQ18]
         end
         auto_init_cnt_r <= auto_init_cnt_r - 4'h1;
      end
   end

   // Pin levels settle through three stages; a change counts once two agree
   always_ff @(posedge CLK) begin
      if (SRST) begin
         open_sync_r <= 3'h0;
         short_sync_r <= 3'h0;
         open_stable_r <= 1'b0;
         short_stable_r <= 1'b0;
      end else if (CE) begin
         open_sync_r <= {open_sync_r[1:0], PIN_OPEN_OR_SUPPLY};
         short_sync_r <= {short_sync_r[1:0], PIN_SHORT_GROUND};
         if (open_sync_r[1] == open_sync_r[2]) begin
            open_stable_r <= open_sync_r[2];
         end
         if (short_sync_r[1] == short_sync_r[2]) begin
            short_stable_r <= short_sync_r[2];
         end
      end
   end

   // Calibration engine; once a fault is latched no calibration is accepted
   always_ff @(posedge CLK) begin
      if (SRST) begin
         cal_busy_r <= 1'b0;
         cal_is_init_r <= 1'b0;
         cal_cnt_r <= 8'h00;
         cal_pin_selftest_info_r <= dmib_pkg::ST_NOT_SUPPORTED;
      end else if (CE) begin
         if (!cal_busy_r && (CAL_INIT_CMD || CAL_CMD) && !fault) begin // [RQ5]
            cal_busy_r <= 1'b1;
            cal_is_init_r <= CAL_INIT_CMD;
            cal_cnt_r <= dmib_pkg::CAL_CYCLES;
         end else if (cal_busy_r) begin
            cal_cnt_r <= cal_cnt_r - 8'h01;
            if (cal_cnt_r == 8'h01) begin
               cal_busy_r <= 1'b0;
               // An ordinary calibration leaves the field as it is
               if (cal_is_init_r && SELFTEST_EN) begin // [RQ4]
                  if (open_stable_r) begin
                     cal_pin_selftest_info_r <= dmib_pkg::ST_OPEN_OR_SUPPLY; // [RQ2]
                  end else if (short_stable_r) begin
                     cal_pin_selftest_info_r <= dmib_pkg::ST_SHORT_GROUND; // [RQ2]
                  end else begin
                     cal_pin_selftest_info_r <= dmib_pkg::ST_PASS; // [RQ3]
                  end
               end
            end
         end
      end
   end

   // Registered copies keep every output straight from a flop
   always_ff @(posedge CLK) begin
      if (SRST) begin
         FACTORY_TRIM <= 1'b0;
         CAL_BUSY <= 1'b0;
         BURST_LENGTH_SEL <= dmib_pkg::RST_BL;
         WRITE_RECOVERY_CYCLES <= 4'h0;
      end else if (CE) begin
         FACTORY_TRIM <= fault; // [RQ5]
         CAL_BUSY <= cal_busy_r;
         BURST_LENGTH_SEL <= burst_length_sel_r;
         WRITE_RECOVERY_CYCLES <= wr_cycles;
      end
   end

   // Column generation: beat index XOR for interleaved, add for sequential
   always_comb begin
      col_nxt = base_col_r;
      // No-wrap adds across the whole column, so y+3 may carry upward
      if (nowrap_r) begin
         col_nxt = base_col_r + {8'h00, beat_r}; // [RQ12]
      end else if (order_int_r) begin
         col_nxt[3:0] = base_col_r[3:0] ^ (beat_r & beats_m1_r); // [RQ14]
      end else begin
         col_nxt[3:0] = (base_col_r[3:0] & ~beats_m1_r) |
                        ((base_col_r[3:0] + beat_r) & beats_m1_r); // [RQ12] [RQ13]
      end
   end

   always_ff @(posedge CLK) begin
      if (SRST) begin
         BURST_ACTIVE <= 1'b0;
         COL_OUT <= 12'h000;
         base_col_r <= 12'h000;
         beat_r <= 4'h0;
         beats_m1_r <= 4'h3;
         order_int_r <= 1'b0;
         nowrap_r <= 1'b0;
         is_wr_ap_r <= 1'b0;
      end else if (CE) begin
         if (BURST_START && !BURST_ACTIVE) begin
            BURST_ACTIVE <= 1'b1;
            base_col_r <= {BURST_COL[11:1], 1'b0}; // [RQ15]
            beat_r <= 4'h0;
            beats_m1_r <= beats_m1_nxt;
            // Four-beat order is the same for both types
            order_int_r <= burst_order_type_r && (burst_length_sel_r != dmib_pkg::BL_CODE_4); // [RQ12]
            nowrap_r <= wrap_control_sel_r; // [RQ14]
            is_wr_ap_r <= BURST_WRITE_AP;
         end else if (BURST_ACTIVE) begin
            COL_OUT <= col_nxt;
            beat_r <= beat_r + 4'h1;
            if (beat_r == beats_m1_r) begin
               BURST_ACTIVE <= 1'b0;
            end
         end
      end
   end

   // Recovery counts from the last beat; precharge is a single-cycle pulse
   always_ff @(posedge CLK) begin
      if (SRST) begin
         wr_state_r <= dmib_pkg::WR_IDLE;
         wr_cnt_r <= 4'h0;
         PRECHARGE_START <= 1'b0;
      end else if (CE) begin
         PRECHARGE_START <= 1'b0;
         case (wr_state_r)
            dmib_pkg::WR_IDLE: begin
               if (BURST_ACTIVE && is_wr_ap_r && beat_r == beats_m1_r) begin
                  wr_cnt_r <= wr_cycles; // [RQ10]
                  wr_state_r <= dmib_pkg::WR_WAIT;
               end
            end
            dmib_pkg::WR_WAIT: begin
               wr_cnt_r <= wr_cnt_r - 4'h1;
               if (wr_cnt_r == 4'h1) begin
                  wr_state_r <= dmib_pkg::WR_PRECHARGE; // [RQ10]
               end
            end
            dmib_pkg::WR_PRECHARGE: begin
               PRECHARGE_START <= 1'b1;
               wr_state_r <= dmib_pkg::WR_IDLE;
            end
            default: wr_state_r <= dmib_pkg::WR_IDLE;
         endcase
      end
   end
endmodule

// ---- sim/dmib_ctrl_model.sv ----
// Purpose: Controller model issuing mode register reads and writes
// Assumes: Requests change after a CLK edge and hold to the taking edge
// Notes: Released address and data lines carry the inverse of the last value; wr and rd return low
`timescale 1ns/10ps
module dmib_ctrl_model (
   input wire logic clk,
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   output logic wr = 1'b0,
   output logic rd = 1'b0,
   output logic [7:0] addr = 8'hFF,
   output logic [7:0] wdata = 8'h00
);
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
      #1 q = rvalid ? rdata : 8'hXX;
   endtask
   // No-wrap is only asked for with four beats
   function automatic logic [7:0] cfg_word(input int len, input logic bt, input logic wc, input int write_recovery_time);
      int n;
      n = (write_recovery_time + 49) / 50;
      return {3'(n - 2), wc & (len == 4), bt, len == 4 ? dmib_pkg::BL_CODE_4 :
         len == 8 ? dmib_pkg::BL_CODE_8 : dmib_pkg::BL_CODE_16};
   endfunction
endmodule

// ---- sim/dmib_top_sva.sv ----
// Purpose: Port-level checks of mode reads, calibration and bursts
// Assumes: CE held high by the bench
// Notes: Config outputs are checked two cycles after the write is taken
`timescale 1ns/10ps
module dmib_top_sva (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic MODE_WR,
   input wire logic MODE_RD,
   input wire logic [7:0] MODE_ADDR,
   input wire logic [7:0] MODE_WDATA,
   input wire logic CAL_CMD,
   input wire logic BURST_START,
   input wire logic [7:0] MODE_RDATA,
   input wire logic MODE_RVALID,
   input wire logic CAL_BUSY,
   input wire logic FACTORY_TRIM,
   input wire logic BURST_ACTIVE,
   input wire logic [11:0] COL_OUT,
   input wire logic PRECHARGE_START,
   input wire logic [2:0] BURST_LENGTH_SEL,
   input wire logic [3:0] WRITE_RECOVERY_CYCLES
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);
   // Write operand delayed to line up with the two-cycle check
   logic [7:0] wdata_d1_r;
   logic [7:0] wdata_d2_r;
   always_ff @(posedge CLK) begin
      wdata_d1_r <= MODE_WDATA;
      wdata_d2_r <= wdata_d1_r;
   end
   property p_wr_dec;
      MODE_WR && MODE_ADDR == 8'h01 && MODE_WDATA[7:5] inside {[3'h1:3'h6]}
         |-> ##2 WRITE_RECOVERY_CYCLES == {1'b0, wdata_d2_r[7:5]} + 4'h2;
   endproperty
   property p_bl;
      MODE_WR && MODE_ADDR == 8'h01 |-> ##2 BURST_LENGTH_SEL == wdata_d2_r[2:0];
   endproperty
   AST_INFO_ZERO: assert property (MODE_RVALID |-> MODE_RDATA[7:5] == 3'h0 && !MODE_RDATA[2])
      else $error("reserved or invalid-data bit set");
   AST_RD_ANS: assert property (MODE_RD |=> MODE_RVALID)
      else $error("read not answered");
   AST_TRIM_FIELD: assert property (MODE_RVALID && $past(MODE_ADDR) == 8'h00 |-> FACTORY_TRIM == ^MODE_RDATA[4:3])
      else $error("trim flag disagrees with field");
   AST_CAL_DROP: assert property (FACTORY_TRIM && CAL_CMD |-> ##2 !CAL_BUSY)
      else $error("calibration run despite fault");
   AST_WR_DEC: assert property (p_wr_dec)
      else $error("recovery cycles wrong");
   AST_BL_COPY: assert property (p_bl)
      else $error("length code wrong");
   AST_BURST_ON: assert property (BURST_START && !BURST_ACTIVE |=> BURST_ACTIVE)
      else $error("burst not started");
   AST_COL_EVEN: assert property ($rose(BURST_ACTIVE) |=> !COL_OUT[0])
      else $error("first column odd");
   AST_PRE_PULSE: assert property (PRECHARGE_START |=> !PRECHARGE_START)
      else $error("precharge pulse too long");
   cover property (BURST_START && !BURST_ACTIVE);
   cover property (PRECHARGE_START);
   cover property ($rose(FACTORY_TRIM));
endmodule

// ---- sim/dmib_top_tb.sv ----
// Purpose: Self-checking bench for mode info, feature register and bursts
// Assumes: CE tied high; controller model drives the mode command lines
// Notes: Random bursts come from an LFSR seeded with 11
`timescale 1ns/10ps
module dmib_top_tb;
   logic CLK = 1'b0, SRST = 1'b1, CAL_INIT_CMD = 1'b0, CAL_CMD = 1'b0, SELFTEST_EN = 1'b0;
   logic PIN_OPEN_OR_SUPPLY = 1'b0, PIN_SHORT_GROUND = 1'b0, BURST_START = 1'b0, BURST_WRITE_AP = 1'b0;
   logic [11:0] BURST_COL = 12'h000;
   logic MODE_WR, MODE_RD, MODE_RVALID, CAL_BUSY, FACTORY_TRIM, BURST_ACTIVE, PRECHARGE_START;
   logic [7:0] MODE_ADDR, MODE_WDATA, MODE_RDATA;
   logic [11:0] COL_OUT;
   logic [2:0] BURST_LENGTH_SEL;
   logic [3:0] WRITE_RECOVERY_CYCLES;
   int err_total = 0, total_checks = 0;
   localparam logic [1:0] EXP_ST [4] = '{2'h0, 2'h3, 2'h1, 2'h2};
   dmib_top DUT (.CLK(CLK), .SRST(SRST), .CE(1'b1), .MODE_WR(MODE_WR), .MODE_RD(MODE_RD),
      .MODE_ADDR(MODE_ADDR), .MODE_WDATA(MODE_WDATA), .CAL_INIT_CMD(CAL_INIT_CMD), .CAL_CMD(CAL_CMD),
      .SELFTEST_EN(SELFTEST_EN), .PIN_OPEN_OR_SUPPLY(PIN_OPEN_OR_SUPPLY), .PIN_SHORT_GROUND(PIN_SHORT_GROUND),
      .BURST_START(BURST_START), .BURST_COL(BURST_COL), .BURST_WRITE_AP(BURST_WRITE_AP),
      .MODE_RDATA(MODE_RDATA), .MODE_RVALID(MODE_RVALID), .CAL_BUSY(CAL_BUSY), .FACTORY_TRIM(FACTORY_TRIM),
      .BURST_ACTIVE(BURST_ACTIVE), .COL_OUT(COL_OUT), .PRECHARGE_START(PRECHARGE_START),
      .BURST_LENGTH_SEL(BURST_LENGTH_SEL), .WRITE_RECOVERY_CYCLES(WRITE_RECOVERY_CYCLES));
   dmib_ctrl_model m (.clk(CLK), .rdata(MODE_RDATA), .rvalid(MODE_RVALID), .wr(MODE_WR), .rd(MODE_RD),
      .addr(MODE_ADDR), .wdata(MODE_WDATA));
   initial begin
      forever #25 CLK = ~CLK;
   end
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      if (err_total == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Column bit 0 is dropped before ordering
   function automatic logic [11:0] exp_col(input logic [11:0] c, input int len, input logic bt, input logic wc, input int k);
      logic [11:0] s;
      s = {c[11:1], 1'b0};
      if (wc) return s + 12'(k);
      if (bt) return s ^ 12'(k);
      return (s & ~12'(len - 1)) | ((s + 12'(k)) & 12'(len - 1));
   endfunction
   task automatic pulse(input logic init);
      @(posedge CLK);
      if (init) begin
         CAL_INIT_CMD <= 1'b1;
      end else begin
         CAL_CMD <= 1'b1;
      end
      @(posedge CLK);
      CAL_INIT_CMD <= 1'b0;
      CAL_CMD <= 1'b0;
   endtask
   task automatic burst(input int len, input logic bt, input logic wc, input int write_recovery_cycles, input logic [11:0] col, input logic ap);
      int n;
      @(posedge CLK);
      BURST_START <= 1'b1;
      BURST_COL <= col;
      BURST_WRITE_AP <= ap;
      @(posedge CLK);
      BURST_START <= 1'b0;
      for (int k = 0; k < len; k++) begin
         @(posedge CLK);
         BURST_START <= (k == 1);
         #1 chk(COL_OUT, exp_col(col, len, bt, wc, k));
      end
      n = 0;
      while (!PRECHARGE_START && n < 20) begin
         @(posedge CLK);
         #1 n++;
      end
      chk(12'(n), ap ? 12'(write_recovery_cycles + 1) : 12'd20);
   endtask
   task automatic run(input int len, input logic bt, input logic wc, input int write_recovery_time, input logic [11:0] col, input logic ap);
      logic [7:0] w, q;
      w = m.cfg_word(len, bt, wc, write_recovery_time);
      m.xfer(1'b1, 8'h01, w, q);
      repeat (2) @(posedge CLK);
      #1 chk(BURST_LENGTH_SEL, w[2:0]);
      chk(WRITE_RECOVERY_CYCLES, {1'b0, w[7:5]} + 4'h2);
      burst(len, w[3], w[4], w[7:5] + 2, col, ap);
   endtask
   initial begin
      logic [15:0] r;
      logic [7:0] q;
      int len;
      r = 16'h000B;
      for (int i = 0; i < 4; i++) begin
         @(posedge CLK);
         SRST <= 1'b1;
         SELFTEST_EN <= (i != 0);
         PIN_OPEN_OR_SUPPLY <= (i == 2);
         PIN_SHORT_GROUND <= (i == 3);
         repeat (2) @(posedge CLK);
         SRST <= 1'b0;
         m.xfer(1'b0, 8'h00, 8'h00, q);
         chk(q, 8'h01);
         chk(BURST_LENGTH_SEL, dmib_pkg::BL_CODE_4);
         repeat (12) @(posedge CLK);
         pulse(1'b1);
         repeat (25) @(posedge CLK);
         m.xfer(1'b1, 8'h00, 8'hFF, q);
         m.xfer(1'b0, 8'h00, 8'h00, q);
         chk(q, {3'h0, EXP_ST[i], 3'h0});
         chk(FACTORY_TRIM, i > 1);
         chk(BURST_LENGTH_SEL, dmib_pkg::BL_CODE_4);
         pulse(1'b0);
         @(posedge CLK);
         #1 chk(CAL_BUSY, i < 2);
      end
      burst(4, 1'b0, 1'b0, 3, 12'h00A, 1'b1);
      run(8, 1'b1, 1'b0, 400, 12'h006, 1'b1);
      run(4, 1'b0, 1'b1, 101, 12'h7F3, 1'b0);
      for (int j = 0; j < 20; j++) begin
         r = nxt(r);
         len = 4 << (r[1:0] % 3);
         run(len, r[2] && len != 16, r[3], 101 + r[15:8] % 300, r[11:0], r[12]);
      end
      finish_test();
   end
   initial begin
      repeat (6000) @(posedge CLK);
      err_total++;
      finish_test();
   end
endmodule
bind dmib_top dmib_top_sva u_sva (.CLK(CLK), .SRST(SRST), .MODE_WR(MODE_WR), .MODE_RD(MODE_RD),
   .MODE_ADDR(MODE_ADDR), .MODE_WDATA(MODE_WDATA), .CAL_CMD(CAL_CMD), .BURST_START(BURST_START),
   .MODE_RDATA(MODE_RDATA), .MODE_RVALID(MODE_RVALID), .CAL_BUSY(CAL_BUSY), .FACTORY_TRIM(FACTORY_TRIM),
   .BURST_ACTIVE(BURST_ACTIVE), .COL_OUT(COL_OUT), .PRECHARGE_START(PRECHARGE_START),
   .BURST_LENGTH_SEL(BURST_LENGTH_SEL), .WRITE_RECOVERY_CYCLES(WRITE_RECOVERY_CYCLES));
